// ---- hdl/bulk_data_file_control.sv ----
`timescale 1ns/1ps

module bulk_data_file_control (
	input  wire logic            i_clk,
	input  wire logic            i_rstn,
	input  wire logic            i_cfg_name_wr,
	input  wire bulk_pkg::name_t i_cfg_name,
	input  wire logic            i_cfg_ctrl_wr,
	input  wire logic [7:0]      i_cfg_ctrl,
	input  wire logic            i_shd_name_wr,
	input  wire bulk_pkg::name_t i_shd_name,
	input  wire logic            i_shd_ctrl_wr,
	input  wire logic [7:0]      i_shd_ctrl,
	input  wire bulk_pkg::name_t i_boot_cfg_link,
	input  wire bulk_pkg::name_t i_boot_shd_link,
	input  wire logic            i_mv_ready,
	input  wire logic            i_mv_done,
	output logic                 o_mv_valid,
	output bulk_pkg::name_t      o_mv_src,
	output bulk_pkg::name_t      o_mv_dst,
	output logic                 o_link_wr,
	output bulk_pkg::name_t      o_cfg_link,
	output bulk_pkg::name_t      o_shd_link,
	output logic [7:0]           o_cfg_status,
	output logic [7:0]           o_shd_status,
	output logic                 o_busy
);
	import bulk_pkg::*;

	typedef struct packed {
		seq_state_t state;
		logic [1:0] boot_step;
		op_t        op;
		name_t      cfg_link;
		name_t      shd_link;
		logic       link_wr;
	} seq_reg_t;

	logic       rst_meta;
	logic       rst_sync;
	seq_reg_t   q;
	seq_reg_t   d;
	bulk_cmd_if cmd ();

	// ------------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	bulk_cmd_decode u_dec (
		.i_clk         (i_clk),
		.i_rstn        (rst_sync),
		.i_cfg_name_wr (i_cfg_name_wr),
		.i_cfg_name    (i_cfg_name),
		.i_cfg_ctrl_wr (i_cfg_ctrl_wr),
		.i_cfg_ctrl    (i_cfg_ctrl),
		.i_shd_name_wr (i_shd_name_wr),
		.i_shd_name    (i_shd_name),
		.i_shd_ctrl_wr (i_shd_ctrl_wr),
		.i_shd_ctrl    (i_shd_ctrl),
		.o_cfg_status  (o_cfg_status),
		.o_shd_status  (o_shd_status),
		.cmd           (cmd.dec)
	);

	// ------------------------------------------------------------------------
	// Transfer sequencer
	// ------------------------------------------------------------------------
	always_comb begin
		d         = q;
		d.link_wr = 1'b0;
		case (q.state)
			// Boot loads the linked files, falling back to factory files.
			ST_START: begin
				d.op = '0;
				if (q.boot_step == 2'h3) begin
					// Links are caught from non-volatile storage first.
					d.boot_step = 2'h0;
					d.cfg_link  = i_boot_cfg_link;
					d.shd_link  = i_boot_shd_link;
				end else if (q.boot_step == 2'h0) begin
					d.op.src = is_cfg_file(q.cfg_link) ? q.cfg_link
						: `NAME_FACTORY_CFG;
					d.op.dst = `LOC_WORK_CFG;
					d.state  = ST_ISSUE;
				end else begin
					d.op.src = is_shd_file(q.shd_link) ? q.shd_link
						: `NAME_FACTORY_SHD;
					d.op.dst = `LOC_VOL_SHD;
					d.state  = ST_ISSUE;
				end
			end
			ST_IDLE: begin
				if (cmd.req_valid) begin
					d.op    = cmd.req_op;
					d.state = ST_ISSUE;
				end
			end
			ST_ISSUE: begin
				if (i_mv_ready) begin
					d.state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (i_mv_done) begin
					d.state = ST_LINK;
				end
			end
			ST_LINK: begin
				if (q.op.lnk_cfg) begin
					d.cfg_link = q.op.src;
				end
				if (q.op.lnk_shd) begin
					d.shd_link = q.op.src;
				end
				d.link_wr = q.op.lnk_cfg || q.op.lnk_shd;
				if (q.boot_step == 2'h0) begin
					d.boot_step = 2'h1;
					d.state     = ST_START;
				end else begin
					d.boot_step = 2'h2;
					d.state     = ST_IDLE;
				end
			end
			default: begin
				d.state = ST_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			q.state     <= ST_START;
			q.boot_step <= 2'h3;
			q.op        <= '0;
			q.cfg_link  <= `RST_NAME;
			q.shd_link  <= `RST_NAME;
			q.link_wr   <= 1'b0;
		end else begin
			q <= d;
		end
	end

	assign cmd.req_ready = (q.state == ST_IDLE);
	assign o_mv_valid    = (q.state == ST_ISSUE);
	assign o_mv_src      = q.op.src;
	assign o_mv_dst      = q.op.dst;
	assign o_link_wr     = q.link_wr;
	assign o_cfg_link    = q.cfg_link;
	assign o_shd_link    = q.shd_link;
	assign o_busy        = (q.state != ST_IDLE);

endmodule : bulk_data_file_control

// ---- hdl/bulk_params.svh ----
`ifndef BULK_PARAMS_SVH
`define BULK_PARAMS_SVH

// ----------------------------------------------------------------------------
// File names carried in the name fields
// ----------------------------------------------------------------------------
`define NAME_USER_CFG_1      8'h01
`define NAME_USER_CFG_2      8'h02
`define NAME_USER_CFG_3      8'h03
`define NAME_USER_CFG_4      8'h04
`define NAME_FACTORY_CFG     8'h10
`define NAME_USER_SHD        8'h20
`define NAME_FACTORY_SHD     8'h21

// ----------------------------------------------------------------------------
// Volatile locations used as copy source or target
// ----------------------------------------------------------------------------
`define LOC_WORK_CFG         8'hF0
`define LOC_VOL_SHD          8'hF1

// ----------------------------------------------------------------------------
// Function codes written to the control fields
// ----------------------------------------------------------------------------
`define FUNC_ACTIVATE        8'h05
`define FUNC_COPY            8'h06

// ----------------------------------------------------------------------------
// Status values and reset values
// ----------------------------------------------------------------------------
`define STAT_OK              8'h01
`define STAT_RANGE           8'h80
`define RST_NAME             8'h00
`define RST_STAT             8'h01

`endif

// ---- hdl/bulk_pkg.sv ----
package bulk_pkg;

`include "bulk_params.svh"

	typedef logic [7:0] name_t;

	typedef struct packed {
		name_t src;
		name_t dst;
		logic  lnk_cfg;
		logic  lnk_shd;
	} op_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_ISSUE = 3'h1,
		ST_WAIT  = 3'h3,
		ST_LINK  = 3'h2,
		ST_START = 3'h6
	} seq_state_t;

	function automatic logic is_user_cfg(input name_t n);
		return (n == `NAME_USER_CFG_1) || (n == `NAME_USER_CFG_2) ||
			(n == `NAME_USER_CFG_3) || (n == `NAME_USER_CFG_4);
	endfunction : is_user_cfg

	function automatic logic is_cfg_file(input name_t n);
		return is_user_cfg(n) || (n == `NAME_FACTORY_CFG);
	endfunction : is_cfg_file

	function automatic logic is_shd_file(input name_t n);
		return (n == `NAME_USER_SHD) || (n == `NAME_FACTORY_SHD);
	endfunction : is_shd_file

endpackage : bulk_pkg

// ---- hdl/bulk_cmd_if.sv ----
`timescale 1ns/1ps

interface bulk_cmd_if;
	import bulk_pkg::*;

	logic req_valid;
	logic req_ready;
	op_t  req_op;

	modport dec (output req_valid, output req_op, input req_ready);
	modport seq (input req_valid, input req_op, output req_ready);
endinterface : bulk_cmd_if

// ---- hdl/bulk_cmd_decode.sv ----
`timescale 1ns/1ps

module bulk_cmd_decode (
	input  wire logic           i_clk,
	input  wire logic           i_rstn,
	input  wire logic           i_cfg_name_wr,
	input  wire bulk_pkg::name_t i_cfg_name,
	input  wire logic           i_cfg_ctrl_wr,
	input  wire logic [7:0]     i_cfg_ctrl,
	input  wire logic           i_shd_name_wr,
	input  wire bulk_pkg::name_t i_shd_name,
	input  wire logic           i_shd_ctrl_wr,
	input  wire logic [7:0]     i_shd_ctrl,
	output logic [7:0]          o_cfg_status,
	output logic [7:0]          o_shd_status,
	bulk_cmd_if.dec             cmd
);
	import bulk_pkg::*;

	typedef struct packed {
		name_t      cfg_name;
		name_t      shd_name;
		logic [7:0] cfg_stat;
		logic [7:0] shd_stat;
		logic       req_valid;
		op_t        req_op;
	} dec_state_t;

	dec_state_t q;
	dec_state_t d;

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb begin
		op_t  op;
		logic ok;
		logic free;
		d    = q;
		op   = '0;
		ok   = 1'b0;
		free = !q.req_valid;
		if (q.req_valid && cmd.req_ready) begin
			d.req_valid = 1'b0;
		end
		if (i_cfg_name_wr) begin
			d.cfg_name = i_cfg_name;
		end
		if (i_shd_name_wr) begin
			d.shd_name = i_shd_name;
		end
		if (i_cfg_ctrl_wr) begin
			if (i_cfg_ctrl == `FUNC_COPY && is_user_cfg(d.cfg_name)) begin
				op.src = `LOC_WORK_CFG;
				op.dst = d.cfg_name;
				ok     = 1'b1;
			end else if (i_cfg_ctrl == `FUNC_COPY &&
				d.shd_name == `NAME_USER_SHD) begin
				op.src = `NAME_FACTORY_SHD;
				op.dst = `NAME_USER_SHD;
				ok     = 1'b1;
			end else if (i_cfg_ctrl == `FUNC_ACTIVATE &&
				is_cfg_file(d.cfg_name)) begin
				op.src     = d.cfg_name;
				op.dst     = `LOC_WORK_CFG;
				op.lnk_cfg = 1'b1;
				ok         = 1'b1;
			end
			ok = ok && free;
			d.cfg_stat = ok ? `STAT_OK : `STAT_RANGE;
			if (ok) begin
				d.req_valid = 1'b1;
				d.req_op    = op;
				free        = 1'b0;
			end
		end
		if (i_shd_ctrl_wr) begin
			op = '0;
			ok = 1'b0;
			if (i_shd_ctrl == `FUNC_ACTIVATE && is_shd_file(d.shd_name)) begin
				op.src     = d.shd_name;
				op.dst     = `LOC_VOL_SHD;
				op.lnk_shd = 1'b1;
				ok         = 1'b1;
			end else if (i_shd_ctrl == `FUNC_COPY &&
				d.shd_name == `NAME_USER_SHD) begin
				op.src = `NAME_FACTORY_SHD;
				op.dst = `NAME_USER_SHD;
				ok     = 1'b1;
			end
			ok = ok && free;
			d.shd_stat = ok ? `STAT_OK : `STAT_RANGE;
			if (ok) begin
				d.req_valid = 1'b1;
				d.req_op    = op;
			end
		end
	end

	// ------------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			q.cfg_name  <= `RST_NAME;
			q.shd_name  <= `RST_NAME;
			q.cfg_stat  <= `RST_STAT;
			q.shd_stat  <= `RST_STAT;
			q.req_valid <= 1'b0;
			q.req_op    <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_cfg_status  = q.cfg_stat;
	assign o_shd_status  = q.shd_stat;
	assign cmd.req_valid = q.req_valid;
	assign cmd.req_op    = q.req_op;

endmodule : bulk_cmd_decode

// ---- tb/bulk_mover_model.sv ----
`timescale 1ns/1ps

// ---------------------------------------------
// File mover answering promptly or slowly.
// ---------------------------------------------
module bulk_mover_model (
	input  wire logic i_clk,
	input  wire logic i_rstn,
	input  wire logic i_valid,
	input  wire logic i_slow,
	output logic      o_ready,
	output logic      o_done
);
	logic       busy_q;
	logic [3:0] cnt_q;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_ready <= 1'b0;
			o_done <= 1'b0;
			busy_q <= 1'b0;
			cnt_q <= 4'h0;
		end else begin
			o_done <= 1'b0;
			if (busy_q) begin
				if (cnt_q == 4'h0) begin
					o_done <= 1'b1;
					busy_q <= 1'b0;
				end else
					cnt_q <= cnt_q - 4'h1;
			end else if (i_valid && o_ready) begin
				o_ready <= 1'b0;
				busy_q <= 1'b1;
				cnt_q <= i_slow ? 4'h9 : 4'h1;
			end else if (i_valid) begin
				if (cnt_q == 4'h0)
					o_ready <= 1'b1;
				else
					cnt_q <= cnt_q - 4'h1;
			end else
				cnt_q <= i_slow ? 4'h4 : 4'h0;
		end
	end
endmodule : bulk_mover_model

// ---- tb/bulk_data_file_control_assertions.sv ----
`timescale 1ns/1ps

// ---------------------------------------------
// Checks on the file control ports.
// ---------------------------------------------
module bulk_data_file_control_assertions (
	input wire logic            i_clk,
	input wire logic            i_rstn,
	input wire logic            i_cfg_name_wr,
	input wire bulk_pkg::name_t i_cfg_name,
	input wire logic            i_cfg_ctrl_wr,
	input wire logic [7:0]      i_cfg_ctrl,
	input wire logic            i_shd_name_wr,
	input wire bulk_pkg::name_t i_shd_name,
	input wire logic            i_shd_ctrl_wr,
	input wire logic [7:0]      i_shd_ctrl,
	input wire bulk_pkg::name_t i_boot_cfg_link,
	input wire logic            o_mv_valid,
	input wire bulk_pkg::name_t o_mv_src,
	input wire bulk_pkg::name_t o_mv_dst,
	input wire logic            o_link_wr,
	input wire bulk_pkg::name_t o_cfg_link,
	input wire bulk_pkg::name_t o_shd_link,
	input wire logic [7:0]      o_cfg_status,
	input wire logic            o_busy
);
	import bulk_pkg::*;
	logic  wr_q;
	name_t cfg_nm_q, shd_nm_q;
	logic  quiet, cgo, sgo, ucfg, cact, sact;
	name_t boot_src;

	// A request is only judged when none is already pending.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_q     <= 1'b0;
			cfg_nm_q <= 8'h00;
			shd_nm_q <= 8'h00;
		end else begin
			wr_q <= i_cfg_ctrl_wr || i_shd_ctrl_wr;
			if (cact)
				cfg_nm_q <= i_cfg_name;
			if (sact)
				shd_nm_q <= i_shd_name;
		end
	end
	assign quiet = !o_busy && !wr_q;
	assign cgo = i_cfg_ctrl_wr && i_cfg_name_wr && quiet;
	assign sgo = i_shd_ctrl_wr && i_shd_name_wr && !i_cfg_ctrl_wr && quiet;
	assign ucfg = (i_cfg_name >= 8'h01) && (i_cfg_name <= 8'h04);
	assign cact = cgo && i_cfg_ctrl == 8'h05 && (ucfg || i_cfg_name == 8'h10);
	assign sact = sgo && i_shd_ctrl == 8'h05 && i_shd_name[7:1] == 7'h10;
	assign boot_src = (i_boot_cfg_link >= 8'h01 && i_boot_cfg_link <= 8'h04)
		? i_boot_cfg_link : 8'h10;

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	save_move_a: assert property (
		cgo && i_cfg_ctrl == 8'h06 && ucfg |-> ##2 o_mv_valid &&
		o_mv_src == 8'hF0 && o_mv_dst == $past(i_cfg_name, 2))
		else $error("save move wrong");
	cfg_move_a: assert property (
		cact |-> ##2 o_mv_valid && o_mv_dst == 8'hF0 &&
		o_mv_src == $past(i_cfg_name, 2)) else $error("cfg load wrong");
	cfg_link_a: assert property (
		cact |-> ##[3:60] (o_link_wr && o_cfg_link == cfg_nm_q))
		else $error("cfg link wrong");
	shd_move_a: assert property (
		sact |-> ##2 o_mv_valid && o_mv_dst == 8'hF1 &&
		o_mv_src == $past(i_shd_name, 2)) else $error("shd load wrong");
	shd_link_a: assert property (
		sact |-> ##[3:60] (o_link_wr && o_shd_link == shd_nm_q))
		else $error("shd link wrong");
	shd_copy_a: assert property (
		sgo && i_shd_ctrl == 8'h06 && i_shd_name == 8'h20 |-> ##2
		o_mv_valid && o_mv_src == 8'h21 && o_mv_dst == 8'h20)
		else $error("shd copy wrong");
	bad_code_a: assert property (
		cgo && i_cfg_ctrl != 8'h05 && i_cfg_ctrl != 8'h06 |=>
		o_cfg_status == 8'h80 ##1 !o_busy) else $error("bad code taken");
	boot_load_a: assert property (
		$rose(i_rstn) |-> ##[2:10] (o_mv_valid && o_mv_dst == 8'hF0 &&
		o_mv_src == boot_src)) else $error("boot load wrong");

	cover property (cgo && i_cfg_ctrl == 8'h06);
	cover property (sact);
	cover property (o_link_wr);
endmodule : bulk_data_file_control_assertions

bind bulk_data_file_control bulk_data_file_control_assertions chk (
	.i_clk(i_clk), .i_rstn(i_rstn), .i_cfg_name_wr(i_cfg_name_wr),
	.i_cfg_name(i_cfg_name), .i_cfg_ctrl_wr(i_cfg_ctrl_wr),
	.i_cfg_ctrl(i_cfg_ctrl), .i_shd_name_wr(i_shd_name_wr),
	.i_shd_name(i_shd_name), .i_shd_ctrl_wr(i_shd_ctrl_wr),
	.i_shd_ctrl(i_shd_ctrl), .i_boot_cfg_link(i_boot_cfg_link),
	.o_mv_valid(o_mv_valid), .o_mv_src(o_mv_src), .o_mv_dst(o_mv_dst),
	.o_link_wr(o_link_wr), .o_cfg_link(o_cfg_link),
	.o_shd_link(o_shd_link), .o_cfg_status(o_cfg_status),
	.o_busy(o_busy));

// ---- tb/tb_bulk_data_file_control.sv ----
`timescale 1ns/1ps

// ---------------------------------------------
// Scenarios for the file control block.
// ---------------------------------------------
module tb_bulk_data_file_control;
	import bulk_pkg::*;
	logic       clk, rstn, cnw, ccw, snw, scw, slow, mvv, mvr, mvd, lwr, busy;
	name_t      cn, sn, bc, bs, src, dst, clk_l, shd_l;
	logic [7:0] cc, sc, cst, sst;
	int         n_errors, compares, k;
	logic [7:0] cc_list [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07};

	bulk_data_file_control dut (.i_clk(clk), .i_rstn(rstn),
		.i_cfg_name_wr(cnw), .i_cfg_name(cn), .i_cfg_ctrl_wr(ccw),
		.i_cfg_ctrl(cc), .i_shd_name_wr(snw), .i_shd_name(sn),
		.i_shd_ctrl_wr(scw), .i_shd_ctrl(sc), .i_boot_cfg_link(bc),
		.i_boot_shd_link(bs), .i_mv_ready(mvr), .i_mv_done(mvd),
		.o_mv_valid(mvv), .o_mv_src(src), .o_mv_dst(dst), .o_link_wr(lwr),
		.o_cfg_link(clk_l), .o_shd_link(shd_l), .o_cfg_status(cst),
		.o_shd_status(sst), .o_busy(busy));
	bulk_mover_model mover (.i_clk(clk), .i_rstn(rstn), .i_valid(mvv),
		.i_slow(slow), .o_ready(mvr), .o_done(mvd));

	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end

	task chk(input string w, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", w, e, g);
		end
	endtask : chk

	task close_out;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	task idle;
		for (k = 0; k < 90 && busy !== 1'b0; k++) @(negedge clk);
		chk("busy", 8'h00, {7'h00, busy});
	endtask : idle

	task mv_at(input name_t s, input name_t d);
		for (k = 0; k < 60 && mvv !== 1'b1; k++) @(negedge clk);
		chk("mv_valid", 8'h01, {7'h00, mvv});
		chk("mv_src", s, src);
		chk("mv_dst", d, dst);
	endtask : mv_at

	task mv(input name_t s, input name_t d);
		mv_at(s, d);
		idle();
	endtask : mv

	task cmd(input logic c, input name_t n, input logic [7:0] f);
		@(negedge clk);
		{cnw, ccw, cn, cc} = {c, c, n, f};
		{snw, scw, sn, sc} = {!c, !c, n, f};
		@(negedge clk);
		{cnw, ccw, snw, scw} = 4'h0;
	endtask : cmd

	task t_reset(input name_t b, input name_t s);
		rstn = 0;
		{bc, bs} = {b, s};
		repeat (6) @(negedge clk);
		rstn = 1;
		mv_at((b >= 8'h01 && b <= 8'h04) ? b : 8'h10, 8'hF0);
		for (k = 0; k < 60 && mvv !== 1'b0; k++) @(negedge clk);
		mv((s == 8'h20) ? 8'h20 : 8'h21, 8'hF1);
		chk("link_wr", 8'h00, {7'h00, lwr});
		chk("cfg_status", 8'h01, cst);
	endtask : t_reset

	task t_save;
		for (int n = 1; n <= 4; n++) begin
			cmd(1, n[7:0], 8'h06);
			chk("cfg_status", 8'h01, cst);
			mv(8'hF0, n[7:0]);
			chk("link_wr", 8'h00, {7'h00, lwr});
		end
	endtask : t_save

	task t_act(input logic c, input name_t n);
		cmd(c, n, 8'h05);
		mv(n, c ? 8'hF0 : 8'hF1);
		chk("link_wr", 8'h01, {7'h00, lwr});
		chk("link", n, c ? clk_l : shd_l);
	endtask : t_act

	task t_bad;
		cmd(1, 8'h10, 8'h06);
		chk("cfg_status", 8'h80, cst);
		foreach (cc_list[i]) begin
			cmd(1, 8'h01, cc_list[i]);
			chk("cfg_status", 8'h80, cst);
		end
		cmd(0, 8'h01, 8'h05);
		chk("shd_status", 8'h80, sst);
		idle();
		chk("cfg_link", 8'h10, clk_l);
		chk("shd_link", 8'h21, shd_l);
	endtask : t_bad

	task t_copy;
		cmd(0, 8'h20, 8'h06);
		mv(8'h21, 8'h20);
		cmd(1, 8'h10, 8'h06);
		mv(8'h21, 8'h20);
	endtask : t_copy

	task t_b2b;
		@(negedge clk);
		{cnw, ccw, cn, cc} = {2'b11, 8'h01, 8'h05};
		@(negedge clk);
		cn = 8'h02;
		@(negedge clk);
		{cnw, ccw} = 2'b00;
		chk("cfg_status", 8'h80, cst);
		mv(8'h01, 8'hF0);
		chk("cfg_link", 8'h01, clk_l);
	endtask : t_b2b

	initial begin
		{cnw, ccw, snw, scw, slow, rstn} = 6'h00;
		{cn, sn, bc, bs, cc, sc} = 48'h0;
		t_reset(8'h00, 8'h00);
		t_save;
		t_act(1, 8'h01);
		t_act(1, 8'h10);
		slow = 1;
		t_act(0, 8'h20);
		t_act(0, 8'h21);
		t_bad;
		t_copy;
		t_b2b;
		t_reset(8'h03, 8'h20);
		close_out;
	end

	initial begin
		#2000000;
		n_errors++;
		close_out;
	end
endmodule : tb_bulk_data_file_control
